//--- rtl/spe_protect_rw.sv
// Purpose: Command, protection and array logic of a serial EEPROM slave.
// Assumes: Serial clock is far slower than clk; mode 0 framing.
// Notes:   Read bytes pass a prefetch FIFO; write bytes gather in a page buffer.
`timescale 1ns/1ps
`include "spe_cfg.svh"

// ---------------------------------------------------------------
// Prefetch FIFO
// ---------------------------------------------------------------
module spe_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         ce,
  input  wire logic         flush,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  // Pointers and fill level.
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } spe_fifo_s;
  spe_fifo_s      f_q, f_d;        // Registered state and its next value.
  logic [W-1:0]   mem [D];         // Storage words.
  logic           push, pop;       // Accepted transfers this cycle.

  assign in_ready  = (f_q.cnt != (AW+1)'(D));
  assign out_valid = (f_q.cnt != '0);
  assign out_data  = mem[f_q.rp];
  assign push      = in_valid & in_ready & ~flush;
  assign pop       = out_valid & out_ready & ~flush;

  // Next pointers; a flush empties the FIFO in one cycle.
  always_comb begin
    f_d = f_q;
    if (flush) begin
      f_d = '0;
    end else begin
      if (push) begin
        f_d.wp = (f_q.wp == AW'(D-1)) ? '0 : f_q.wp + 1'b1;
      end
      if (pop) begin
        f_d.rp = (f_q.rp == AW'(D-1)) ? '0 : f_q.rp + 1'b1;
      end
      f_d.cnt = f_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // State register; low enable freezes everything.
  always_ff @(posedge clk) begin
    if (srst) begin
      f_q <= '0;
    end else if (ce) begin
      f_q <= f_d;
    end
  end

  // Storage write.
  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem[f_q.wp] <= in_data;
    end
  end
endmodule : spe_fifo

// ---------------------------------------------------------------
// Top module
// ---------------------------------------------------------------
module spe_protect_rw import spe_pkg::*; #(
  parameter int unsigned WRITE_CYCLES = `SPE_WCYC_NS / `SPE_CLK_NS
) (
  input  wire logic  clk,
  input  wire logic  srst,
  input  wire logic  ce,
  input  spe_pins_s  pins,
  output logic       spi_miso,
  output logic       spi_miso_oe,
  output logic       busy_flag,
  output logic       hardware_protected_mode,
  output logic [7:0] protection_status
);
  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  // Hamming encode: data in non-power positions, parity at 1,2,4,..,32.
  function automatic logic [37:0] spe_ecc_enc(input logic [31:0] d);
    logic [37:0] c;
    int k;
    c = '0;
    k = 0;
    for (int p = 1; p <= 38; p++) begin
      if ((p & (p - 1)) != 0) begin
        c[p-1] = d[k];
        k++;
      end
    end
    for (int j = 0; j < 6; j++) begin
      for (int i = 0; i < 38; i++) begin
        if ((((i + 1) >> j) & 1) == 1) begin
          c[(1 << j) - 1] = c[(1 << j) - 1] ^ c[i];
        end
      end
    end
    return c;
  endfunction : spe_ecc_enc

  // Hamming decode: the syndrome names the flipped position.
  function automatic logic [31:0] spe_ecc_dec(input logic [37:0] cw);
    logic [37:0] c;
    logic [5:0]  syn;
    logic [31:0] d;
    int k;
    c = cw;
    syn = '0;
    d = '0;
    k = 0;
    for (int i = 0; i < 38; i++) begin
      // Masking instead of branching lets an unknown bit spoil the syndrome,
      // so a word that was never written passes through raw, not miscorrected.
      syn = syn ^ ({6{c[i]}} & 6'(i + 1));
    end
    if (syn != 6'h00 && syn <= 6'h26) begin
      c[syn-6'h01] = ~c[syn-6'h01];
    end
    for (int p = 1; p <= 38; p++) begin
      if ((p & (p - 1)) != 0) begin
        d[k] = c[p-1];
        k++;
      end
    end
    return d;
  endfunction : spe_ecc_dec

  // Does the page at this address fall in the protected region?
  function automatic logic spe_prot(input logic [1:0] bp, input logic [14:0] a);
    unique case (bp)
      2'b00: spe_prot = 1'b0;
      2'b01: spe_prot = (a >= `SPE_QTR_BASE);
      2'b10: spe_prot = (a >= `SPE_HALF_BASE);
      2'b11: spe_prot = 1'b1;
    endcase
  endfunction : spe_prot

  // ---------------------------------------------------------------
  // Storage and signals
  // ---------------------------------------------------------------
  spe_state_s  st_q, st_d;          // Whole block state.
  logic [37:0] arr [8192];          // Array words with check bits.
  logic [7:0]  pbuf [64];           // Page buffer for one write frame.
  logic [12:0] rd_wa;               // Shared array read word address.
  logic [31:0] rd_word;             // Corrected read word.
  logic        mem_we;              // Array write strobe.
  logic [12:0] mem_wa;              // Array write word address.
  logic [37:0] mem_wd;              // Array write codeword.
  logic        pb_we;               // Page buffer write strobe.
  logic [5:0]  pb_wa;               // Page buffer write index.
  logic [7:0]  pb_wd;               // Page buffer write byte.
  logic        ff_push_v, ff_ready; // Prefetch side of the FIFO.
  logic        ff_out_v, ff_pop;    // Shifter side of the FIFO.
  logic [7:0]  ff_out;              // Next read byte.
  logic        ff_flush;            // Frame ended.

  // Commit walks the page while busy; prefetch reads only when idle.
  assign rd_wa   = st_q.busy ? {st_q.addr[14:6], st_q.widx} : st_q.pf_addr[14:2];
  assign rd_word = spe_ecc_dec(arr[rd_wa]);

  // A byte is pushed ahead of the shifter until the FIFO is full.
  assign ff_push_v = st_q.pf_on & ~st_q.busy;

  spe_fifo #(.W(8), .D(`SPE_FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .srst      (srst),
    .ce        (ce),
    .flush     (ff_flush),
    .in_valid  (ff_push_v),
    .in_data   (rd_word[{st_q.pf_addr[1:0], 3'b000} +: 8]),
    .in_ready  (ff_ready),
    .out_valid (ff_out_v),
    .out_data  (ff_out),
    .out_ready (ff_pop)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic sclk_rise;
    logic sclk_fall;
    logic cs_low;
    logic cs_rise;
    logic [7:0] b;
    logic [7:0] src;
    logic [3:0] m;
    logic [31:0] w;
    sclk_rise = 1'b0;
    sclk_fall = 1'b0;
    cs_low = 1'b0;
    cs_rise = 1'b0;
    b = '0;
    src = '0;
    m = '0;
    w = '0;
    st_d = st_q;
    mem_we = 1'b0;
    mem_wa = '0;
    mem_wd = '0;
    pb_we = 1'b0;
    pb_wa = st_q.woff;
    pb_wd = '0;
    ff_pop = 1'b0;
    ff_flush = 1'b0;

    // Two flops on mosi and wp_n, three on sclk and cs_n; edges compare the second and third stages.
    st_d.sclk_s = {st_q.sclk_s[1:0], pins.sclk};
    st_d.cs_s   = {st_q.cs_s[1:0], pins.cs_n};
    st_d.mosi_s = {st_q.mosi_s[0], pins.mosi};
    st_d.wp_s   = {st_q.wp_s[0], pins.wp_n};
    sclk_rise = st_q.sclk_s[1] & ~st_q.sclk_s[2];
    sclk_fall = ~st_q.sclk_s[1] & st_q.sclk_s[2];
    cs_low    = ~st_q.cs_s[1];
    cs_rise   = st_q.cs_s[1] & ~st_q.cs_s[2];

    // Live protection mode, so pin and bit may change in either order.
    st_d.hw_lock = st_q.lock & ~st_q.wp_s[1];

    // Back end: write the page word by word, then wait out the time.
    unique case (st_q.bk)
      B_IDLE: begin
      end
      B_COMMIT: begin
        m = st_q.mask[{st_q.widx, 2'b00} +: 4];
        w = rd_word;
        for (int k = 0; k < 4; k++) begin
          if (m[k]) begin
            w[k*8 +: 8] = pbuf[{st_q.widx, 2'(k)}];
          end
        end
        // Any touched byte rewrites the whole word and its check bits.
        mem_we = |m;
        mem_wa = {st_q.addr[14:6], st_q.widx};
        mem_wd = spe_ecc_enc(w);
        st_d.widx = st_q.widx + 4'h1;
        if (st_q.widx == 4'hf) begin
          st_d.bk = B_WAIT;
          st_d.tmr = '0;
        end
      end
      B_WAIT: begin
        st_d.tmr = st_q.tmr + 32'h1;
        if (st_q.tmr >= 32'(WRITE_CYCLES - 1)) begin
          st_d.bk = B_IDLE;
          st_d.busy = 1'b0;
          st_d.wr_latch = 1'b0;
          if (st_q.sr_kind) begin
            st_d.lock = st_q.new_sr[`SPE_SR_LOCK];
            st_d.bp = st_q.new_sr[`SPE_SR_BPHI:`SPE_SR_BPLO];
          end
        end
      end
    endcase

    // Prefetch advances on each accepted push and wraps at the top.
    if (ff_push_v && ff_ready) begin
      st_d.pf_addr = st_q.pf_addr + 15'h1;
    end

    // Serial input: sample on rising clock, most significant bit first.
    if (cs_low && sclk_rise && st_q.fr != F_IGN) begin
      b = {st_q.ish[6:0], st_q.mosi_s[1]};
      st_d.ish = b;
      st_d.bit3 = st_q.bit3 + 3'h1;
      if (st_q.bit3 == 3'h7) begin
        if (st_q.nbytes != 4'hf) begin
          st_d.nbytes = st_q.nbytes + 4'h1;
        end
        unique case (st_q.fr)
          F_OPC: begin
            st_d.mask = '0;
            // Unknown opcodes deselect the device until chip select rises.
            unique case (b)
              `SPE_OP_ENWR:  st_d.fr = F_WEN;
              `SPE_OP_RDSR:  st_d.fr = F_RDSR;
              `SPE_OP_SRWR:  st_d.fr = F_SRD;
              `SPE_OP_READ: begin
                st_d.fr = st_q.busy ? F_IGN : F_ADR;
                st_d.rd_cmd = 1'b1;
              end
              `SPE_OP_WRITE: begin
                st_d.fr = F_ADR;
                st_d.rd_cmd = 1'b0;
              end
              default: st_d.fr = F_IGN;
            endcase
          end
          F_ADR: begin
            if (st_q.nbytes == 4'h1) begin
              st_d.addr[14:8] = b[6:0];
            end else begin
              st_d.addr[7:0] = b;
              st_d.fr = st_q.rd_cmd ? F_RD : F_WR;
              st_d.pf_on = st_q.rd_cmd;
              st_d.pf_addr = {st_q.addr[14:8], b};
              st_d.woff = b[5:0];
            end
          end
          F_WR: begin
            pb_we = 1'b1;
            pb_wd = b;
            st_d.mask[st_q.woff] = 1'b1;
            st_d.woff = st_q.woff + 6'h1;
          end
          default: begin
          end
        endcase
      end
    end

    // Serial output: new bit on falling clock; a byte loads at its start.
    if (cs_low && sclk_fall && (st_q.fr == F_RD || st_q.fr == F_RDSR)) begin
      st_d.oe = 1'b1;
      if (st_q.bit3 == 3'h0) begin
        src = (st_q.fr == F_RD) ? ff_out : st_q.sr_out;
        ff_pop = (st_q.fr == F_RD);
        st_d.miso = src[7];
        st_d.osh = {src[6:0], 1'b0};
      end else begin
        st_d.miso = st_q.osh[7];
        st_d.osh = {st_q.osh[6:0], 1'b0};
      end
    end

    // Chip select high ends the frame; commands commit on its rise.
    if (!cs_low) begin
      st_d.oe = 1'b0;
      st_d.pf_on = 1'b0;
      st_d.fr = F_OPC;
      st_d.bit3 = '0;
      st_d.nbytes = '0;
      ff_flush = 1'b1;
    end
    if (cs_rise && st_q.bit3 == 3'h0) begin
      unique case (st_q.fr)
        F_WEN: begin
          if (st_q.nbytes == 4'h1) begin
            st_d.wr_latch = 1'b1;
          end
        end
        F_SRD: begin
          if (st_q.nbytes == `SPE_SRW_BYTES && st_q.wr_latch && !st_q.busy && !st_q.hw_lock) begin
            st_d.bk = B_WAIT;
            st_d.tmr = '0;
            st_d.busy = 1'b1;
            st_d.sr_kind = 1'b1;
            // Taken only on acceptance, so a refused frame sent during a
            // running cycle cannot alter the value that cycle will commit.
            st_d.new_sr = st_q.ish;
          end
        end
        F_WR: begin
          if (st_q.nbytes >= `SPE_WR_BYTES && st_q.wr_latch && !st_q.busy
              && !spe_prot(st_q.bp, st_q.addr)) begin
            st_d.bk = B_COMMIT;
            st_d.widx = '0;
            st_d.busy = 1'b1;
            st_d.sr_kind = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // Status byte with b6..b4 forced to zero.
    st_d.sr_out = {st_d.lock, 3'b000, st_d.bp, st_d.wr_latch, st_d.busy};
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // State register; chip select idles high after reset.
  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= '0;
      st_q.cs_s <= 3'b111;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  // Array and page buffer writes.
  always_ff @(posedge clk) begin
    if (ce && mem_we) begin
      arr[mem_wa] <= mem_wd;
    end
    if (ce && pb_we) begin
      pbuf[pb_wa] <= pb_wd;
    end
  end

  assign spi_miso = st_q.miso;
  assign spi_miso_oe = st_q.oe;
  assign busy_flag = st_q.busy;
  assign hardware_protected_mode = st_q.hw_lock;
  assign protection_status = st_q.sr_out;
endmodule : spe_protect_rw

//--- rtl/spe_cfg.svh
// Purpose: Constants of the serial EEPROM command and protection logic.
// Assumes: Included by bare name; definitions only.
// Notes:   Offsets, field positions, reset values and times in ns.
`ifndef SPE_CFG_SVH
`define SPE_CFG_SVH
// Opcodes, shifted in most significant bit first.
`define SPE_OP_ENWR   8'h06
`define SPE_OP_RDSR   8'h05
`define SPE_OP_SRWR   8'h01
`define SPE_OP_READ   8'h03
`define SPE_OP_WRITE  8'h02
// Status byte field positions and reset value.
`define SPE_SR_LOCK   7
`define SPE_SR_BPHI   3
`define SPE_SR_BPLO   2
`define SPE_SR_LATCH  1
`define SPE_SR_BUSY   0
`define SPE_SR_RESET  8'h00
// Start addresses of the protected quarter and half.
`define SPE_QTR_BASE  15'h6000
`define SPE_HALF_BASE 15'h4000
// Frame lengths in whole bytes, opcode included.
`define SPE_SRW_BYTES 4'h2
`define SPE_WR_BYTES  4'h4
// Self-timed write time in ns and clock period in ns.
`define SPE_WCYC_NS   100000
`define SPE_CLK_NS    100
`define SPE_FIFO_DEPTH 32
`endif

//--- rtl/spe_pkg.sv
// Purpose: Types of the serial EEPROM command and protection logic.
// Assumes: Constants live in spe_cfg.svh.
// Notes:   The whole state of the top module is one packed struct.
package spe_pkg;
  // Front end: where the serial frame stands.
  typedef enum logic [2:0] {F_OPC, F_WEN, F_RDSR, F_SRD, F_ADR, F_RD, F_WR, F_IGN} spe_front_e;
  // Back end: the self-timed write cycle.
  typedef enum logic [1:0] {B_IDLE, B_COMMIT, B_WAIT} spe_back_e;
  // Serial pins coming from the master.
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic mosi;
    logic wp_n;
  } spe_pins_s;
  // Complete register state of the top module.
  typedef struct packed {
    logic [2:0]  sclk_s;
    logic [2:0]  cs_s;
    logic [1:0]  mosi_s;
    logic [1:0]  wp_s;
    spe_front_e  fr;
    spe_back_e   bk;
    logic [2:0]  bit3;
    logic [3:0]  nbytes;
    logic [7:0]  ish;
    logic [7:0]  osh;
    logic        rd_cmd;
    logic [14:0] addr;
    logic [5:0]  woff;
    logic [63:0] mask;
    logic        pf_on;
    logic [14:0] pf_addr;
    logic [7:0]  new_sr;
    logic        sr_kind;
    logic        lock;
    logic [1:0]  bp;
    logic        wr_latch;
    logic [3:0]  widx;
    logic [31:0] tmr;
    logic        miso;
    logic        oe;
    logic        busy;
    logic        hw_lock;
    logic [7:0]  sr_out;
  } spe_state_s;
endpackage : spe_pkg

//--- tb/spe_chk.sv
// Purpose: Port checker of the serial EEPROM command and protection block.
// Assumes: ce held high by the bench; sees only top module ports.
// Notes:   Bound to every spe_protect_rw instance at the foot of this file.
`timescale 1ns/1ps
module spe_chk import spe_pkg::*; #(
  parameter int unsigned WRITE_CYCLES = 1000
) (
  input wire logic  clk,
  input wire logic  srst,
  input wire logic  ce,
  input spe_pins_s  pins,
  input wire logic  spi_miso,
  input wire logic  spi_miso_oe,
  input wire logic  busy_flag,
  input wire logic  hardware_protected_mode,
  input wire logic [7:0] protection_status
);
  // ---------------------------------------------------------------
  // Helper logic
  // ---------------------------------------------------------------
  logic [31:0] bcnt_q; // Busy cycles so far; a counter avoids a long repetition.
  // Count busy cycles, restarting whenever busy is low.
  always_ff @(posedge clk) begin
    bcnt_q <= (srst || !busy_flag) ? 32'h0 : bcnt_q + 32'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  property p_b654; protection_status[6:4] == 3'h0; endproperty
  a_b654: assert property (p_b654) else $error("status bits 6 to 4 not zero");
  property p_busybit; $changed(busy_flag) |-> ##[0:1] (protection_status[0] == busy_flag); endproperty
  a_busybit: assert property (p_busybit) else $error("status busy bit disagrees");
  property p_hwmode_on; (!pins.wp_n && protection_status[7]) [*5] |-> hardware_protected_mode; endproperty
  a_hwmode_on: assert property (p_hwmode_on) else $error("protected mode not entered");
  property p_hwmode_off;
    $fell(hardware_protected_mode) |-> pins.wp_n || $past(pins.wp_n) || $past(pins.wp_n, 2)
      || $past(pins.wp_n, 3) || $past(pins.wp_n, 4);
  endproperty
  a_hwmode_off: assert property (p_hwmode_off) else $error("protected mode left with pin low");
  property p_lock_hold; hardware_protected_mode |=> $stable(protection_status[7:2]); endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("locked status bits changed");
  property p_busy_len;
    $fell(busy_flag) |-> (bcnt_q >= WRITE_CYCLES - 1) && (bcnt_q <= WRITE_CYCLES + 20);
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("write cycle length wrong");
  property p_wel_clr; $fell(busy_flag) |-> ##[0:1] !protection_status[1]; endproperty
  a_wel_clr: assert property (p_wel_clr) else $error("enable latch kept after cycle");
  property p_oe_drop; pins.cs_n [*5] |-> !spi_miso_oe; endproperty
  a_oe_drop: assert property (p_oe_drop) else $error("output driven while deselected");
  property p_sr_upd;
    $changed(protection_status[7:2]) |-> !busy_flag && ($past(busy_flag) || $past(busy_flag, 2));
  endproperty
  a_sr_upd: assert property (p_sr_upd) else $error("protect bits changed outside cycle end");
  c_busy: cover property ($rose(busy_flag));
  c_hwmode: cover property ($rose(hardware_protected_mode));
  c_oe: cover property ($rose(spi_miso_oe));
endmodule : spe_chk

bind spe_protect_rw spe_chk #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (
  .clk(clk), .srst(srst), .ce(ce), .pins(pins), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
  .busy_flag(busy_flag), .hardware_protected_mode(hardware_protected_mode),
  .protection_status(protection_status));

//--- tb/spe_master.sv
// Purpose: Behavioural SPI mode 0 bus master facing the EEPROM block.
// Assumes: Serial clock of 8 clk periods, still outside frames.
// Notes:   A released output line is read as the inverse of the last bit.
`timescale 1ns/1ps
module spe_master (
  input  wire logic  clk,
  input  wire logic  miso,
  input  wire logic  oe,
  output logic       sclk,
  output logic       cs_n,
  output logic       mosi,
  output logic       rx_stb,
  output logic [7:0] rx_byte,
  output logic       oe_seen
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
    rx_stb = 1'b0;
    rx_byte = 8'h00;
    oe_seen = 1'b0;
  end
  // ---------------------------------------------------------------
  // One frame: whole bytes plus xb loose bits; bytes from slot skip on are strobed out.
  // ---------------------------------------------------------------
  task automatic frame(input logic [7:0] tx [$], input int xb, input int skip);
    int nb;
    logic [7:0] sh;
    nb = tx.size() * 8 + xb;
    sh = 8'h00;
    oe_seen = 1'b0;
    @(posedge clk);
    #2 cs_n = 1'b0;
    for (int i = 0; i < nb; i++) begin
      mosi = (i / 8 < tx.size()) ? tx[i / 8][7 - i % 8] : 1'($urandom);
      repeat (4) @(posedge clk);
      #2 sclk = 1'b1;
      repeat (4) @(posedge clk);
      #1 sh = {sh[6:0], oe ? miso : ~sh[0]};
      oe_seen = oe_seen | oe;
      #1 sclk = 1'b0;
      if (i % 8 == 7 && i / 8 >= skip) begin
        rx_byte = sh;
        rx_stb = 1'b1;
        // Scheduled drop keeps the next data bit on the usual 2 ns offset.
        rx_stb <= #1 1'b0;
      end
    end
    // Deselect after the last rise and before another would come.
    repeat (2) @(posedge clk);
    #2 cs_n = 1'b1;
    mosi = ~mosi;
    repeat (8) @(posedge clk);
  endtask : frame
endmodule : spe_master

//--- tb/testbench.sv
// Purpose: Self-checking bench of the EEPROM command and protection block.
// Assumes: Write cycle shortened to 200 clk so a status poll fits inside it.
// Notes:   Read bytes are checked by a monitor against a queue of notes.
`timescale 1ns/1ps
`include "spe_cfg.svh"
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin err_total++; \
  $display("ERROR %s exp %h got %h", nm, e, s); end end
module testbench import spe_pkg::*; ;
  logic        clk = 1'b0;
  logic        srst, ce, wp_n, sclk, cs_n, mosi, spi_miso, spi_miso_oe, busy_flag, hw_mode;
  logic [7:0]  protection_status;
  spe_pins_s   pins;
  int          err_total = 0;
  int          n_tests = 0;
  logic [7:0]  exp_q [$];             // Expected read bytes, oldest first.
  logic [7:0]  shadow [logic [14:0]]; // Array contents written so far.
  logic [15:0] at [3] = '{16'he000, 16'h4000, 16'h0000}; // Region bases; bit 15 ignored.
  always #50 clk = ~clk;
  assign pins = '{sclk: sclk, cs_n: cs_n, mosi: mosi, wp_n: wp_n};
  spe_protect_rw #(.WRITE_CYCLES(200)) u_dut (.clk(clk), .srst(srst), .ce(ce), .pins(pins),
    .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .busy_flag(busy_flag),
    .hardware_protected_mode(hw_mode), .protection_status(protection_status));
  spe_master u_mst (.clk(clk), .miso(spi_miso), .oe(spi_miso_oe), .sclk(sclk), .cs_n(cs_n),
    .mosi(mosi), .rx_stb(), .rx_byte(), .oe_seen());
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic results();
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  task automatic tend(input string s);
    $display("test %s done", s);
  endtask : tend
  // Bounded wait for the write cycle to end.
  task automatic wait_idle();
    for (int k = 0; k < 600 && busy_flag !== 1'b0; k++) @(posedge clk);
    repeat (3) @(posedge clk);
    `CHK("cycle end", 1'b0, busy_flag)
  endtask : wait_idle
  task automatic wen();
    u_mst.frame('{`SPE_OP_ENWR}, 0, 99);
  endtask : wen
  task automatic rdsr(input logic [7:0] e);
    exp_q.push_back(e);
    u_mst.frame('{`SPE_OP_RDSR, 8'h00}, 0, 1);
  endtask : rdsr
  // Status write; while accepted the status is polled mid-cycle.
  task automatic srw(input logic [7:0] v, input logic ok);
    logic [7:0] old;
    wait_idle();
    old = protection_status;
    wen();
    u_mst.frame('{`SPE_OP_SRWR, v}, 0, 99);
    `CHK("status start", ok, busy_flag)
    if (ok) rdsr({old[7:2], 2'h3});
    wait_idle();
    `CHK("status end", ok ? {v[7], 3'h0, v[3:2], 2'h0} : {old[7:2], 2'h2}, protection_status)
  endtask : srw
  task automatic wr(input logic [15:0] a, input int n, input logic en, input int xb, input logic ok);
    logic [7:0] q [$];
    logic [7:0] d;
    wait_idle();
    if (en) wen();
    q = '{`SPE_OP_WRITE, a[15:8], a[7:0]};
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      q.push_back(d);
      if (ok) shadow[{a[14:6], a[5:0] + 6'(i)}] = d;
    end
    u_mst.frame(q, xb, 99);
    `CHK("write start", ok, busy_flag)
  endtask : wr
  task automatic rd(input logic [15:0] a, input int n);
    logic [7:0] q [$];
    wait_idle();
    q = '{`SPE_OP_READ, a[15:8], a[7:0]};
    for (int i = 0; i < n; i++) begin
      q.push_back(8'h00);
      exp_q.push_back(shadow[a[14:0] + 15'(i)]);
    end
    u_mst.frame(q, 0, 3);
  endtask : rd
  // ---------------------------------------------------------------
  // Monitor: each received byte is matched against the oldest note.
  // ---------------------------------------------------------------
  always @(posedge u_mst.rx_stb) begin
    logic [7:0] e;
    e = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
    `CHK("read byte", e, u_mst.rx_byte)
  end
  // Watchdog, far beyond the roughly 1.5 ms the tests need.
  initial begin
    #8_000_000;
    err_total++;
    results();
  end
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    srst = 1'b1;
    ce = 1'b1;
    wp_n = 1'b1;
    void'($urandom(58));
    repeat (6) @(posedge clk);
    #2 srst = 1'b0;
    repeat (6) @(posedge clk);
    `CHK("reset status", 8'h00, protection_status)
    `CHK("reset mode", 1'b0, hw_mode)
    tend("reset");
    u_mst.frame('{`SPE_OP_SRWR, 8'h0c}, 0, 99);
    `CHK("no enable", 1'b0, busy_flag)
    wen();
    u_mst.frame('{`SPE_OP_SRWR, 8'h0c}, 1, 99);
    `CHK("odd length", 1'b0, busy_flag)
    tend("status refusals");
    // Every protect code against every region base.
    for (int b = 0; b < 4; b++) begin
      srw({4'h7, 2'(b), 2'h3}, 1'b1);
      for (int k = 0; k < 3; k++) wr(at[k], 1, 1'b1, 0, 1'(b <= k));
    end
    srw(8'h00, 1'b1);
    tend("protect regions");
    wr(16'h803c, 6, 1'b1, 0, 1'b1);
    rd(16'h003c, 4);
    rd(16'h8000, 2);
    wr(16'h003d, 1, 1'b1, 0, 1'b1);
    rd(16'h003c, 4);
    wr(16'h7ffe, 2, 1'b1, 0, 1'b1);
    u_mst.frame('{`SPE_OP_READ, 8'h00, 8'h3c, 8'h00}, 0, 99);
    `CHK("read in cycle", 1'b0, u_mst.oe_seen)
    rd(16'hfffe, 4);
    wr(16'h0100, 1, 1'b0, 0, 1'b0);
    wr(16'h0100, 1, 1'b1, 3, 1'b0);
    wait_idle();
    u_mst.frame('{`SPE_OP_READ, 8'h00, 8'h3c, 8'h00}, 5, 99);
    `CHK("abort started", 1'b1, u_mst.oe_seen)
    `CHK("abort stops", 1'b0, spi_miso_oe)
    tend("array");
    srw(8'h80, 1'b1);
    `CHK("pin high mode", 1'b0, hw_mode)
    #2 wp_n = 1'b0;
    repeat (6) @(posedge clk);
    `CHK("mode entered", 1'b1, hw_mode)
    srw(8'h00, 1'b0);
    wr(16'h0100, 1, 1'b1, 0, 1'b1);
    wait_idle();
    #2 wp_n = 1'b1;
    repeat (6) @(posedge clk);
    `CHK("mode left", 1'b0, hw_mode)
    srw(8'h00, 1'b1);
    #2 wp_n = 1'b0;
    srw(8'h80, 1'b1);
    `CHK("mode after lock", 1'b1, hw_mode)
    #2 wp_n = 1'b1;
    tend("hardware mode");
    `CHK("notes left", 0, exp_q.size())
    results();
  end
endmodule : testbench
